//--- hw/port_c_pkg.sv
/*
  Constants, register map and carrier types for the upper port C pin mux.
  Assumes a 32-bit AXI4-Lite register bus and a single 40 MHz clock.
*/
// How it works
// - Async transmit selected on pin 6 drives the pin; software clears direction.
// - Sync clock on pin 6: direction 1 takes clock in, 0 drives it out.
// - Sync data on pin 7: direction 1 receives, 0 drives data over the latch.
// - Parallel address on pin 7 sets its own direction; direction bit ignored.
// - Parallel address bit 5 on pin 6: direction 0 drives, 1 accepts from pin.
// - SPI data output of first sync port may drive pin 7 with direction 0.
// - Pins 6 and 7 are remap pins: input when direction 1, output when 0.
// - Pin 7 level goes to async receiver; needs direction bit 1.
// - Parallel address paths exist only on the larger package variant.
// - Pins 4 and 5 have no direction or latch bits; inputs only.
// - Direction register reads back stored value despite peripheral overrides.
package port_c_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_PIN_LEVELS = 8'h00;
  localparam logic [7:0] ADDR_OUTPUT_LATCH = 8'h04;
  localparam logic [7:0] ADDR_DIRECTION = 8'h08;
  localparam logic [7:0] ADDR_FUNC_SEL = 8'h0C;

  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] DIRECTION_RESET = 8'hFF;
  localparam logic [7:0] IMPL_MASK = 8'hC7;
  localparam logic [7:0] INPUT_ONLY_MASK = 8'h30;
  localparam logic [7:0] FUNC_SEL_RESET = 8'h00;

  localparam int PIN6 = 6;
  localparam int PIN7 = 7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Function selects
  typedef enum logic [2:0]
  {
    F6_PORT = 3'b000,
    F6_CAPTURE = 3'b001,
    F6_PAR_ADDR = 3'b010,
    F6_TRANSMIT = 3'b011,
    F6_SYNC_CLOCK = 3'b100,
    F6_REMAP = 3'b101
  } pin6_func_t;

  typedef enum logic [2:0]
  {
    F7_PORT = 3'b000,
    F7_CAPTURE = 3'b001,
    F7_PAR_ADDR = 3'b010,
    F7_RECEIVE = 3'b011,
    F7_SYNC_DATA = 3'b100,
    F7_SPI_OUT = 3'b101,
    F7_REMAP = 3'b110
  } pin7_func_t;

  localparam int SEL6_LSB = 0;
  localparam int SEL7_LSB = 4;

  // ==========================================================
  // Peripheral carriers
  typedef struct packed
  {
    logic capture_a_out;
    logic capture_b_out;
    logic addr_bit5_out;
    logic addr_bit4_out;
    logic addr_bit4_oe;
    logic transmit_out;
    logic sync_clock_out;
    logic sync_data_out;
    logic spi_out;
    logic remap_a_out;
    logic remap_b_out;
  } periph_out_t;

  typedef struct packed
  {
    logic capture_a_in;
    logic capture_b_in;
    logic addr_bit5_in;
    logic addr_bit4_in;
    logic receive_in;
    logic sync_clock_in;
    logic sync_data_in;
    logic remap_a_in;
    logic remap_b_in;
  } periph_in_t;

endpackage

//--- hw/upper_pin_mux.sv
/*
  Combinational mux for pins 6 and 7 of port C.
  Assumes registered latch, direction and select values from the top module.
*/
`timescale 1ns/1ps
`default_nettype none
module upper_pin_mux
  import port_c_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b1
)
(
  // Register values
  input wire logic [1:0] latch,
  input wire logic [1:0] direction,
  input wire pin6_func_t sel6,
  input wire pin7_func_t sel7,
  // Peripherals
  input wire periph_out_t from_periph,
  output periph_in_t to_periph,
  // Pin levels and drives
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe
);

  // ==========================================================
  // Pin 6 source and direction
  always_comb
  begin
    pin_out[0] = latch[0];
    pin_oe[0] = ~direction[0];
    case (sel6)
      F6_PORT: pin_out[0] = latch[0];
      F6_CAPTURE: pin_out[0] = from_periph.capture_a_out;
      F6_PAR_ADDR:
      begin
        if (LARGE_PACKAGE)
        begin
          pin_out[0] = from_periph.addr_bit5_out;
        end
      end
      F6_TRANSMIT: pin_out[0] = from_periph.transmit_out;
      F6_SYNC_CLOCK: pin_out[0] = from_periph.sync_clock_out;
      F6_REMAP: pin_out[0] = from_periph.remap_a_out;
      default: pin_out[0] = latch[0];
    endcase
  end

  // ==========================================================
  // Pin 7 source and direction
  always_comb
  begin
    pin_out[1] = latch[1];
    pin_oe[1] = ~direction[1];
    case (sel7)
      F7_PORT: pin_out[1] = latch[1];
      F7_CAPTURE: pin_out[1] = from_periph.capture_b_out;
      F7_PAR_ADDR:
      begin
        if (LARGE_PACKAGE)
        begin
          pin_out[1] = from_periph.addr_bit4_out;
          pin_oe[1] = from_periph.addr_bit4_oe;
        end
      end
      F7_RECEIVE: pin_oe[1] = ~direction[1];
      F7_SYNC_DATA: pin_out[1] = from_periph.sync_data_out;
      F7_SPI_OUT: pin_out[1] = from_periph.spi_out;
      F7_REMAP: pin_out[1] = from_periph.remap_b_out;
      default: pin_out[1] = latch[1];
    endcase
  end

  // ==========================================================
  // Input routing, gated by function and direction; pin 7 address input gated by its own enable
  always_comb
  begin
    to_periph = '0;
    to_periph.capture_a_in = (sel6 == F6_CAPTURE) & direction[0] & pin_in[0];
    to_periph.addr_bit5_in = LARGE_PACKAGE & (sel6 == F6_PAR_ADDR)
      & direction[0] & pin_in[0];
    to_periph.sync_clock_in = (sel6 == F6_SYNC_CLOCK) & direction[0] & pin_in[0];
    to_periph.remap_a_in = (sel6 == F6_REMAP) & direction[0] & pin_in[0];
    to_periph.capture_b_in = (sel7 == F7_CAPTURE) & direction[1] & pin_in[1];
    to_periph.addr_bit4_in = LARGE_PACKAGE & (sel7 == F7_PAR_ADDR)
      & ~from_periph.addr_bit4_oe & pin_in[1];
    to_periph.receive_in = (sel7 == F7_RECEIVE) & direction[1] & pin_in[1];
    to_periph.sync_data_in = (sel7 == F7_SYNC_DATA) & direction[1] & pin_in[1];
    to_periph.remap_b_in = (sel7 == F7_REMAP) & direction[1] & pin_in[1];
  end

endmodule
`default_nettype wire

//--- hw/port_c_upper_pin_mux.sv
/*
  Top of the upper port C pin mux: AXI4-Lite registers and the pin mux.
  Assumes one 40 MHz clock, synchronous active-low reset, synchronous pins.
*/
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module port_c_upper_pin_mux
  import port_c_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b1
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Peripherals
  input wire periph_out_t from_periph,
  output periph_in_t to_periph,
  // Port pins, bit i is pin i; bits 4..5 input only, bit 3 unimplemented
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe
);

  // ==========================================================
  // Registers
  logic [7:0] port_c_output_latch;
  logic [7:0] port_c_direction;
  logic [7:0] func_sel;
  logic [7:0] port_c_pin_levels;
  logic [1:0] mux_out;
  logic [1:0] mux_oe;

  // Write channel state
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == ADDR_PIN_LEVELS) || (addr == ADDR_OUTPUT_LATCH)
      || (addr == ADDR_DIRECTION) || (addr == ADDR_FUNC_SEL);
  endfunction

  // ==========================================================
  // Write address and data capture, either order
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (do_write)
    begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (do_write)
    begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Register update; latch and direction store only implemented bits, func_sel stores all 8
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_c_output_latch <= LATCH_RESET;
      port_c_direction <= DIRECTION_RESET;
      func_sel <= FUNC_SEL_RESET;
    end
    else if (do_write && w_strb[0])
    begin
      case (aw_addr)
        ADDR_PIN_LEVELS, ADDR_OUTPUT_LATCH:
          port_c_output_latch <= w_data[7:0] & IMPL_MASK;
        ADDR_DIRECTION:
          port_c_direction <= (w_data[7:0] & IMPL_MASK) | ~IMPL_MASK;
        ADDR_FUNC_SEL: func_sel <= w_data[7:0];
        default: func_sel <= func_sel;
      endcase
    end
  end

  // ==========================================================
  // Read channel
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        ADDR_PIN_LEVELS: s_axi_rdata <= {24'h00_0000, port_c_pin_levels};
        ADDR_OUTPUT_LATCH: s_axi_rdata <= {24'h00_0000, port_c_output_latch};
        ADDR_DIRECTION: s_axi_rdata <= {24'h00_0000, port_c_direction};
        ADDR_FUNC_SEL: s_axi_rdata <= {24'h00_0000, func_sel};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Pin levels as sampled; bit 3 unimplemented reads zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_c_pin_levels <= 8'h00;
    end
    else
    begin
      port_c_pin_levels <= pin_in & (IMPL_MASK | INPUT_ONLY_MASK);
    end
  end

  // ==========================================================
  // Pin mux for pins 6 and 7
  upper_pin_mux #(
    .LARGE_PACKAGE(LARGE_PACKAGE)
  ) u_mux (
    .latch(port_c_output_latch[PIN7:PIN6]),
    .direction(port_c_direction[PIN7:PIN6]),
    .sel6(pin6_func_t'(func_sel[SEL6_LSB +: 3])),
    .sel7(pin7_func_t'(func_sel[SEL7_LSB +: 3])),
    .from_periph(from_periph),
    .to_periph(to_periph),
    .pin_in(pin_in[PIN7:PIN6]),
    .pin_out(mux_out),
    .pin_oe(mux_oe)
  );

  // ==========================================================
  // Pin drive; lower pins are plain port I/O, pins 4 and 5 never drive
  always_comb
  begin
    pin_out = port_c_output_latch & IMPL_MASK;
    pin_oe = ~port_c_direction & IMPL_MASK;
    pin_out[PIN7:PIN6] = mux_out;
    pin_oe[PIN7:PIN6] = mux_oe;
  end

endmodule
`default_nettype wire

//--- testbench/board_side.sv
/*
  Far-side model: board levels resolved against the mux drive.
  Assumes pin_out and pin_oe from the pin mux.
*/
`timescale 1ns/1ps
`default_nettype none
module board_side
(
  // From the mux
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  // Board drive
  input wire logic [7:0] board,
  // To the mux
  output logic [7:0] pin_in
);
  // ==========================================
  // Pin resolution
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & board);
endmodule
`default_nettype wire

//--- testbench/pin_mux_monitor.sv
/*
  Port checker for the upper port C pin mux.
  Assumes binding to port_c_upper_pin_mux.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_mux_monitor
  import port_c_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Read bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Pins
  input wire periph_in_t to_periph,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_oe
);
  // ==========================================
  // Checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_input_only_pins: assert property (pin_oe[5:3] == 3'h0)
    else $error("input-only pin driven");
  chk_receive_gate: assert property (to_periph.receive_in |-> pin_in[7] && !pin_oe[7])
    else $error("receive level wrong");
  chk_clock_in_gate: assert property (to_periph.sync_clock_in |-> pin_in[6] && !pin_oe[6])
    else $error("clock input wrong");
  chk_data_in_gate: assert property (to_periph.sync_data_in |-> pin_in[7] && !pin_oe[7])
    else $error("data input wrong");
  chk_remap_a_gate: assert property (to_periph.remap_a_in |-> pin_in[6] && !pin_oe[6])
    else $error("remap a input wrong");
  chk_remap_b_gate: assert property (to_periph.remap_b_in |-> pin_in[7] && !pin_oe[7])
    else $error("remap b input wrong");
  chk_addr5_gate: assert property (to_periph.addr_bit5_in |-> pin_in[6] && !pin_oe[6])
    else $error("address input wrong");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
endmodule
bind port_c_upper_pin_mux pin_mux_monitor pin_mux_monitor_i (.aclk, .aresetn, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .to_periph, .pin_in, .pin_oe);
`default_nettype wire

//--- testbench/tb.sv
/*
  Self-checking bench for the upper port C pin mux.
  Assumes the bound checker and board_side for pin levels.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import port_c_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, pin_in, pin_out, pin_oe, board, lat;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  periph_out_t from_periph;
  periph_in_t to_periph;
  int error_cnt, cmp_count;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  port_c_upper_pin_mux port_c_upper_pin_mux_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .from_periph, .to_periph, .pin_in, .pin_out,
    .pin_oe);
  board_side board_side_i (.pin_out, .pin_oe, .board, .pin_in);
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // ==========================================
  // Compare, close and bus tasks
  task automatic cmp(input logic [33:0] g, input logic [33:0] x, input string m);
    cmp_count++;
    if (g !== x)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, x);
    end
  endtask
  task automatic wrap_up();
    $display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic tmo();
    error_cnt++;
    $display("wrong value at %0t: no answer", $time);
    wrap_up();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask
  // ==========================================
  // Result watcher
  always @(posedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready)
      cmp(s_axi_bresp, bq.pop_front(), "bresp");
    if (s_axi_rvalid && s_axi_rready)
      cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front(), "read");
  end
  // ==========================================
  // Expected pin behaviour for one select and direction
  task automatic check_pins(input int k, input logic dv);
    logic [1:0] ox, eo;
    logic [7:0] lv;
    periph_in_t x;
    x = '0;
    eo = {~dv, ~dv};
    ox = lat[7:6];
    case (k)
      1: ox[0] = from_periph.capture_a_out;
      2: ox[0] = from_periph.addr_bit5_out;
      3: ox[0] = from_periph.transmit_out;
      4: ox[0] = from_periph.sync_clock_out;
      5: ox[0] = from_periph.remap_a_out;
      default: ;
    endcase
    case (k)
      1: ox[1] = from_periph.capture_b_out;
      2: {ox[1], eo[1]} = {from_periph.addr_bit4_out, from_periph.addr_bit4_oe};
      4: ox[1] = from_periph.sync_data_out;
      5: ox[1] = from_periph.spi_out;
      6: ox[1] = from_periph.remap_b_out;
      default: ;
    endcase
    if (!eo[0])
      case (k)
        1: x.capture_a_in = board[6];
        2: x.addr_bit5_in = board[6];
        4: x.sync_clock_in = board[6];
        5: x.remap_a_in = board[6];
        default: ;
      endcase
    if (!eo[1])
      case (k)
        1: x.capture_b_in = board[7];
        2: x.addr_bit4_in = board[7];
        3: x.receive_in = board[7];
        4: x.sync_data_in = board[7];
        6: x.remap_b_in = board[7];
        default: ;
      endcase
    cmp(pin_out[7:6] & eo, ox & eo, "pin out");
    cmp(pin_oe, {eo, 6'h00}, "pin oe");
    cmp(to_periph, x, "to periph");
    cmp(pin_out[5:0], lat[5:0] & IMPL_MASK[5:0], "low pins");
    lv = {(eo & ox) | (~eo & board[7:6]), board[5:0]} & (IMPL_MASK | INPUT_ONLY_MASK);
    rd(ADDR_PIN_LEVELS, {RESP_OKAY, 24'h00_0000, lv});
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, board, lat} = '0;
    s_axi_wstrb = 4'hf;
    from_periph = '0;
    void'($urandom(32'hfa39));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_DIRECTION, {RESP_OKAY, 24'h00_0000, DIRECTION_RESET});
    rd(ADDR_OUTPUT_LATCH, {RESP_OKAY, 24'h00_0000, LATCH_RESET});
    rd(ADDR_FUNC_SEL, {RESP_OKAY, 24'h00_0000, FUNC_SEL_RESET});
    rd(8'h10, {RESP_SLVERR, 32'h0000_0000});
    wr(8'h10, 8'h55, RESP_SLVERR);
    wr(ADDR_PIN_LEVELS, 8'hff, RESP_OKAY);
    rd(ADDR_OUTPUT_LATCH, {RESP_OKAY, 24'h00_0000, IMPL_MASK});
    cmp(pin_oe, 8'h00, "oe after reset");
    $display("test reset done");
    for (int k = 0; k < 7; k++)
      for (int d = 0; d < 2; d++)
      begin
        lat = 8'($urandom);
        wr(ADDR_OUTPUT_LATCH, lat, RESP_OKAY);
        wr(ADDR_DIRECTION, {d[0], d[0], 6'h07}, RESP_OKAY);
        wr(ADDR_FUNC_SEL, {1'b0, 3'(k), 1'b0, (k == 6) ? 3'h0 : 3'(k)}, RESP_OKAY);
        rd(ADDR_DIRECTION, {RESP_OKAY, 24'h00_0000, d[0], d[0], 6'h3f});
        rd(ADDR_OUTPUT_LATCH, {RESP_OKAY, 24'h00_0000, lat & IMPL_MASK});
        for (int b = 0; b < 2; b++)
        begin
          @(posedge aclk);
          from_periph <= periph_out_t'($urandom);
          board <= {{2{b[0]}}, 6'($urandom)};
          @(posedge aclk);
          #1;
          check_pins(k, d[0]);
        end
      end
    $display("test function table done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_DIRECTION, {RESP_OKAY, 24'h00_0000, DIRECTION_RESET});
    rd(ADDR_FUNC_SEL, {RESP_OKAY, 24'h00_0000, FUNC_SEL_RESET});
    cmp(pin_oe, 8'h00, "oe after second reset");
    $display("test mid reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
